// *** hdl/uart_fifo_ctrl_int_status.sv ***
// Module: FIFO control, trigger levels and prioritized interrupt status for a UART
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Control bit 0 enables both FIFOs
// - Bit 1 flushes receive FIFO, self-clears
// - Bit 2 flushes transmit FIFO, self-clears
// - Bits 7:6 choose receive trigger 8/16/24/28
// - Receive-ready raised when count reaches trigger
// - Bits 5:4 choose transmit trigger 16/8/24/30
// - Transmit-empty raised when count drops below trigger
// - Nonzero level registers override two-bit fields
// - Status read returns highest pending code
// - Lower source hidden while higher pending
// - Line status is level 1, code 000110
// - Data ready 000100, time-out 001100, level 2
// - Transmit holding empty is level 3, 000010
// - Modem change is level 4, code zero
// - Flow pin change is level 6, 100000
// - Bits 5:4 only with enhanced bit 4
// - Xoff flag holds until Xon received or enhanced bit 4 cleared
// - Status bits 7:6 show FIFO enable
// - Status bit 0 low when pending
// - Receive-ready clears when count drops below
// - Transmit-empty cleared by write or status read reporting it
module uart_fifo_ctrl_int_status
    import uart_ictl_pkg::*;
#(
    parameter int DEPTH = 32,              // FIFO depth in bytes
    parameter int CNT_W = 8                // Width of the fill counters
) (
    input  wire logic                          clk,          // 100 MHz clock
    input  wire logic                          sys_rst,      // Async reset, active high
    input  wire uart_ictl_pkg::reg_req_type    req,          // Register bus request
    output logic [7:0]                         rdata,        // Read data, cycle after read
    input  wire uart_ictl_pkg::uart_events_type events,      // Events from the UART core
    input  wire logic                          rx_push,      // Byte into receive FIFO
    input  wire logic                          rx_pop,       // Byte read out of receive FIFO
    input  wire logic                          tx_push,      // Host writes holding register
    input  wire logic                          tx_pop,       // Serializer takes a byte
    output logic                               fifo_enable,  // FIFO mode on
    output logic                               rx_flush,     // One-cycle receive flush
    output logic                               tx_flush,     // One-cycle transmit flush
    output logic [CNT_W-1:0]                   rx_count,     // Receive fill count
    output logic [CNT_W-1:0]                   tx_count,     // Transmit fill count
    output logic [CNT_W-1:0]                   rx_trigger,   // Active receive trigger level
    output logic                               int_pending   // Any enabled source pending
);
    import uart_ictl_pkg::*;

    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

    logic [7:0]     fcr_q;
    logic [7:0]     ier_q;
    logic [7:0]     efr_q;
    logic [7:0]     rx_lvl_q, tx_lvl_q, flow_hi_q, flow_lo_q;
    logic [CNT_W-1:0] rx_cnt_q, tx_cnt_q;
    logic           rx_flush_q, tx_flush_q;
    logic           tx_empty_q;
    logic           tx_below_q;
    logic           xoff_q, flowpin_q;
    logic [7:0]     rdata_q;
    logic           pend_q;
    logic [CNT_W-1:0] rx_trig_q;

    function automatic logic is_wr(input reg_req_type r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction : is_wr

    function automatic logic is_rd(input reg_req_type r, input logic [3:0] a);
        return r.rd && (r.addr == a);
    endfunction : is_rd

    // Control registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fcr_q <= FIFO_CTRL_RESET;
        end else if (is_wr(req, ADDR_FIFO_CTRL)) begin
            fcr_q <= {req.wdata[7:4], 1'b0, 2'b00, req.wdata[FCR_EN_BIT]};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ier_q     <= INT_ENABLE_RESET;
            efr_q     <= ENH_RESET;
            rx_lvl_q  <= LEVEL_RESET;
            tx_lvl_q  <= LEVEL_RESET;
            flow_hi_q <= LEVEL_RESET;
            flow_lo_q <= LEVEL_RESET;
        end else begin
            if (is_wr(req, ADDR_INT_ENABLE))  ier_q     <= req.wdata;
            if (is_wr(req, ADDR_ENH_FEATURE)) efr_q     <= req.wdata;
            if (is_wr(req, ADDR_RX_LEVEL))    rx_lvl_q  <= req.wdata;
            if (is_wr(req, ADDR_TX_LEVEL))    tx_lvl_q  <= req.wdata;
            if (is_wr(req, ADDR_FLOW_HIGH))   flow_hi_q <= req.wdata;
            if (is_wr(req, ADDR_FLOW_LOW))    flow_lo_q <= req.wdata;
        end
    end

    // Flush strobes: the written bit lives one cycle, then reads back zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_flush_q <= 1'b0;
            tx_flush_q <= 1'b0;
        end else begin
            rx_flush_q <= is_wr(req, ADDR_FIFO_CTRL) && req.wdata[FCR_RXCLR_BIT];
            tx_flush_q <= is_wr(req, ADDR_FIFO_CTRL) && req.wdata[FCR_TXCLR_BIT];
        end
    end

    // Trigger levels
    logic       override;
    logic [7:0] rx_trig8, tx_trig8;
    logic [CNT_W-1:0] rx_trig, tx_trig;

    always_comb begin
        override = (rx_lvl_q != 8'h00) || (tx_lvl_q != 8'h00) ||
                   (flow_hi_q != 8'h00) || (flow_lo_q != 8'h00);
        case (fcr_q[FCR_RXTRG_LSB +: 2])
            2'b00:   rx_trig8 = RX_TRIG_0;
            2'b01:   rx_trig8 = RX_TRIG_1;
            2'b10:   rx_trig8 = RX_TRIG_2;
            default: rx_trig8 = RX_TRIG_3;
        endcase
        case (fcr_q[FCR_TXTRG_LSB +: 2])
            2'b00:   tx_trig8 = TX_TRIG_0;
            2'b01:   tx_trig8 = TX_TRIG_1;
            2'b10:   tx_trig8 = TX_TRIG_2;
            default: tx_trig8 = TX_TRIG_3;
        endcase
        if (override) begin
            rx_trig8 = rx_lvl_q;
            tx_trig8 = tx_lvl_q;
        end
        // Non-FIFO mode behaves as a one-byte holding register
        rx_trig = fcr_q[FCR_EN_BIT] ? CNT_W'(rx_trig8) : CNT_W'(1);
        tx_trig = fcr_q[FCR_EN_BIT] ? CNT_W'(tx_trig8) : CNT_W'(1);
    end

    // Fill counters; a flush drops any byte of the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_cnt_q <= '0;
        end else if (rx_flush_q) begin
            rx_cnt_q <= '0;
        end else if (rx_push && !rx_pop && rx_cnt_q != DEPTH_C) begin
            rx_cnt_q <= rx_cnt_q + CNT_W'(1);
        end else if (rx_pop && !rx_push && rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_cnt_q <= '0;
        end else if (tx_flush_q) begin
            tx_cnt_q <= '0;
        end else if (tx_push && !tx_pop && tx_cnt_q != DEPTH_C) begin
            tx_cnt_q <= tx_cnt_q + CNT_W'(1);
        end else if (tx_pop && !tx_push && tx_cnt_q != '0) begin
            tx_cnt_q <= tx_cnt_q - CNT_W'(1);
        end
    end

    // Receive-ready is a pure level of the count, so it drops by itself
    logic rx_ready;
    assign rx_ready = (rx_cnt_q >= rx_trig);

    // Transmit-empty latches on entry below trigger; write or status read reporting it clears it
    logic tx_below;
    logic isr_read;
    logic tx_selected;
    int_source_type src;
    assign tx_below = (tx_cnt_q < tx_trig);
    assign isr_read = is_rd(req, ADDR_INT_STATUS);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_below_q <= 1'b1;
            tx_empty_q <= 1'b0;
        end else begin
            tx_below_q <= tx_below;
            if (tx_below && !tx_below_q) begin
                tx_empty_q <= 1'b1;
            end else if (tx_push || (isr_read && tx_selected)) begin
                tx_empty_q <= 1'b0;
            end
        end
    end

    // Enhanced-mode sticky flags; set wins over clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            xoff_q    <= 1'b0;
            flowpin_q <= 1'b0;
        end else begin
            if (events.xoff_match && efr_q[EFR_ENH_BIT]) begin
                xoff_q <= 1'b1;
            end else if (events.xon_match || !efr_q[EFR_ENH_BIT]) begin
                xoff_q <= 1'b0;
            end
            if (events.cts_rts_chg && efr_q[EFR_ENH_BIT]) begin
                flowpin_q <= 1'b1;
            end else if ((isr_read && src == SRC_FLOWPIN) || !efr_q[EFR_ENH_BIT]) begin
                flowpin_q <= 1'b0;
            end
        end
    end

    // Priority encoder over enabled sources
    logic [5:0]     code;

    always_comb begin
        src  = SRC_NONE;
        code = 6'h00;
        if (events.line_err && ier_q[IE_LINE]) begin
            src  = SRC_LINE;
            code = CODE_LINE;
        end else if ((rx_ready || events.rx_timeout) && ier_q[IE_RX_DATA]) begin
            src  = SRC_RX;
            code = events.rx_timeout && !rx_ready ? CODE_RX_TOUT : CODE_RX_DATA;
        end else if (tx_empty_q && ier_q[IE_TX_EMPTY]) begin
            src  = SRC_TX;
            code = CODE_TX;
        end else if (events.modem_chg && ier_q[IE_MODEM]) begin
            src  = SRC_MODEM;
            code = CODE_MODEM;
        end else if (xoff_q && efr_q[EFR_ENH_BIT] && ier_q[IE_XOFF]) begin
            src  = SRC_XOFF;
            code = CODE_XOFF;
        end else if (flowpin_q && efr_q[EFR_ENH_BIT] && (ier_q[IE_CTS] || ier_q[IE_RTS])) begin
            src  = SRC_FLOWPIN;
            code = CODE_FLOWPIN;
        end
    end
    assign tx_selected = (src == SRC_TX);

    logic [7:0] isr_val;
    always_comb begin
        isr_val = (src == SRC_NONE) ? STATUS_IDLE : {2'b00, code};
        isr_val[7:6] = {2{fcr_q[FCR_EN_BIT]}};
    end

    // Read port: data stand in the cycle after the strobe only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_INT_STATUS:  rdata_q <= isr_val;
                ADDR_INT_ENABLE:  rdata_q <= ier_q;
                ADDR_ENH_FEATURE: rdata_q <= efr_q;
                ADDR_RX_LEVEL:    rdata_q <= rx_lvl_q;
                ADDR_TX_LEVEL:    rdata_q <= tx_lvl_q;
                ADDR_FLOW_HIGH:   rdata_q <= flow_hi_q;
                ADDR_FLOW_LOW:    rdata_q <= flow_lo_q;
                ADDR_FIFO_STATE:  rdata_q <= 8'(rx_cnt_q);
                default:          rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q    <= 1'b0;
            rx_trig_q <= '0;
        end else begin
            pend_q    <= (src != SRC_NONE);
            rx_trig_q <= rx_trig;
        end
    end

    assign rdata       = rdata_q;
    assign fifo_enable = fcr_q[FCR_EN_BIT];
    assign rx_flush    = rx_flush_q;
    assign tx_flush    = tx_flush_q;
    assign rx_count    = rx_cnt_q;
    assign tx_count    = tx_cnt_q;
    assign rx_trigger  = rx_trig_q;
    assign int_pending = pend_q;

    AST_RX_FLUSH_ONE: assert property (@(posedge clk) disable iff (sys_rst)
        rx_flush_q |=> !rx_flush_q || $past(is_wr(req, ADDR_FIFO_CTRL)))
        else $error("receive flush strobe stuck");
    AST_RX_FLUSH_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        rx_flush_q |=> rx_cnt_q == '0)
        else $error("receive count not cleared by flush");
    AST_TX_FLUSH_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        tx_flush_q |=> tx_cnt_q == '0)
        else $error("transmit count not cleared by flush");
    AST_FIFO_BITS: assert property (@(posedge clk) disable iff (sys_rst)
        isr_read |=> rdata[7:6] == {2{$past(fcr_q[FCR_EN_BIT])}})
        else $error("status bits 7:6 differ from FIFO enable");
    AST_IDLE_BIT: assert property (@(posedge clk) disable iff (sys_rst)
        isr_read |=> rdata[0] == !$past(src != SRC_NONE))
        else $error("status bit 0 wrong");
    AST_LINE_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && events.line_err && ier_q[IE_LINE]) |=> rdata[5:0] == CODE_LINE)
        else $error("line status not reported first");
    AST_RX_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
        (fcr_q[FCR_EN_BIT] && !override && fcr_q[FCR_RXTRG_LSB +: 2] == 2'b01
         && rx_cnt_q >= CNT_W'(RX_TRIG_1)
         && ier_q[IE_RX_DATA] && !(events.line_err && ier_q[IE_LINE])) |-> src == SRC_RX)
        else $error("receive-ready missed at trigger");
    AST_RX_BELOW: assert property (@(posedge clk) disable iff (sys_rst)
        (fcr_q[FCR_EN_BIT] && !override && fcr_q[7:6] == 2'b00 && rx_cnt_q < CNT_W'(8)
         && !events.rx_timeout) |-> src != SRC_RX)
        else $error("receive-ready held below trigger");
    AST_TX_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_push && !(tx_below && !tx_below_q)) |=> !tx_empty_q)
        else $error("transmit-empty not cleared by write");
    AST_DISABLED_HIDDEN: assert property (@(posedge clk) disable iff (sys_rst)
        (ier_q == 8'h00) |-> src == SRC_NONE)
        else $error("disabled source reported");
    AST_XOFF_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (xoff_q && !events.xon_match && efr_q[EFR_ENH_BIT]) |=> xoff_q)
        else $error("xoff flag dropped without xon");
    AST_ENH_GATE: assert property (@(posedge clk) disable iff (sys_rst)
        !efr_q[EFR_ENH_BIT] ##1 !efr_q[EFR_ENH_BIT] |-> !xoff_q && !flowpin_q)
        else $error("enhanced bits set while disabled");

    // Control writes, trigger decode and the reported codes
    AST_FIFO_EN: assert property (@(posedge clk) disable iff (sys_rst)
        is_wr(req, ADDR_FIFO_CTRL) |=> fifo_enable == $past(req.wdata[FCR_EN_BIT]))
        else $error("fifo enable not taken from bit 0");
    AST_RX_FLUSH_SET: assert property (@(posedge clk) disable iff (sys_rst)
        (is_wr(req, ADDR_FIFO_CTRL) && req.wdata[FCR_RXCLR_BIT]) |=> rx_flush)
        else $error("receive flush not raised");
    AST_TX_FLUSH_SET: assert property (@(posedge clk) disable iff (sys_rst)
        (is_wr(req, ADDR_FIFO_CTRL) && req.wdata[FCR_TXCLR_BIT]) |=> tx_flush)
        else $error("transmit flush not raised");
    AST_TX_FLUSH_ONE: assert property (@(posedge clk) disable iff (sys_rst)
        tx_flush_q |=> !tx_flush_q || $past(is_wr(req, ADDR_FIFO_CTRL)))
        else $error("transmit flush strobe stuck");
    AST_RX_TRIG_CODE: assert property (@(posedge clk) disable iff (sys_rst)
        (fcr_q[FCR_EN_BIT] && !override && fcr_q[FCR_RXTRG_LSB +: 2] == 2'b10)
        |-> rx_trig == CNT_W'(RX_TRIG_2))
        else $error("receive trigger code 10 wrong");
    AST_TX_TRIG_CODE: assert property (@(posedge clk) disable iff (sys_rst)
        (fcr_q[FCR_EN_BIT] && !override && fcr_q[FCR_TXTRG_LSB +: 2] == 2'b11)
        |-> tx_trig == CNT_W'(TX_TRIG_3))
        else $error("transmit trigger code 11 wrong");
    AST_OVERRIDE: assert property (@(posedge clk) disable iff (sys_rst)
        (fcr_q[FCR_EN_BIT] && flow_hi_q != 8'h00) |-> rx_trig == CNT_W'(rx_lvl_q))
        else $error("flow level did not hand trigger to level register");
    AST_TX_SET: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_cnt_q < tx_trig && !tx_below_q) |=> tx_empty_q)
        else $error("transmit-empty not raised below trigger");
    AST_TX_READ_CLR: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && src == SRC_TX && tx_below_q) |=> !tx_empty_q)
        else $error("transmit-empty not cleared by status read");
    AST_RX_OVER_TX: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && rx_ready && ier_q[IE_RX_DATA] && !(events.line_err && ier_q[IE_LINE]))
        |=> rdata[5:0] == CODE_RX_DATA)
        else $error("lower source shown over receive-ready");
    AST_TOUT_CODE: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && src == SRC_RX && !rx_ready) |=> rdata[5:0] == CODE_RX_TOUT)
        else $error("time-out code wrong");
    AST_TX_CODE: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && src == SRC_TX) |=> rdata[5:0] == CODE_TX)
        else $error("transmit-empty code wrong");
    AST_MODEM_CODE: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && src == SRC_MODEM) |=> rdata[5:0] == CODE_MODEM)
        else $error("modem code wrong");
    AST_XOFF_CODE: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && src == SRC_XOFF) |=> rdata[5:0] == CODE_XOFF)
        else $error("xoff code wrong");
    AST_FLOWPIN_CODE: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && src == SRC_FLOWPIN) |=> rdata[5:0] == CODE_FLOWPIN)
        else $error("flow pin code wrong");
    AST_ENH_BITS: assert property (@(posedge clk) disable iff (sys_rst)
        (isr_read && !efr_q[EFR_ENH_BIT]) |=> rdata[5:4] == 2'b00)
        else $error("status bits 5:4 set without enhanced mode");
endmodule : uart_fifo_ctrl_int_status

`default_nettype wire

// *** hdl/uart_ictl_pkg.sv ***
// Package: register map, fields, codes and types for the FIFO control and interrupt status block
package uart_ictl_pkg;
    localparam int          ADDR_W           = 4;
    localparam logic [3:0]  ADDR_FIFO_CTRL   = 4'h2;  // Write side of the shared offset
    localparam logic [3:0]  ADDR_INT_STATUS  = 4'h2;  // Read side of the shared offset
    localparam logic [3:0]  ADDR_INT_ENABLE  = 4'h1;
    localparam logic [3:0]  ADDR_ENH_FEATURE = 4'h3;
    localparam logic [3:0]  ADDR_RX_LEVEL    = 4'h4;
    localparam logic [3:0]  ADDR_TX_LEVEL    = 4'h5;
    localparam logic [3:0]  ADDR_FLOW_HIGH   = 4'h6;
    localparam logic [3:0]  ADDR_FLOW_LOW    = 4'h7;
    localparam logic [3:0]  ADDR_FIFO_STATE  = 4'h8;

    localparam int FCR_EN_BIT    = 0;
    localparam int FCR_RXCLR_BIT = 1;
    localparam int FCR_TXCLR_BIT = 2;
    localparam int FCR_TXTRG_LSB = 4;
    localparam int FCR_RXTRG_LSB = 6;
    localparam int EFR_ENH_BIT   = 4;

    localparam int IE_RX_DATA  = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_LINE     = 2;
    localparam int IE_MODEM    = 3;
    localparam int IE_XOFF     = 5;
    localparam int IE_RTS      = 6;
    localparam int IE_CTS      = 7;

    localparam logic [7:0] FIFO_CTRL_RESET  = 8'h00;
    localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] ENH_RESET        = 8'h00;
    localparam logic [7:0] LEVEL_RESET      = 8'h00;
    localparam logic [7:0] STATUS_IDLE      = 8'h01;

    localparam logic [7:0] RX_TRIG_0 = 8'h08;
    localparam logic [7:0] RX_TRIG_1 = 8'h10;
    localparam logic [7:0] RX_TRIG_2 = 8'h18;
    localparam logic [7:0] RX_TRIG_3 = 8'h1C;
    localparam logic [7:0] TX_TRIG_0 = 8'h10;
    localparam logic [7:0] TX_TRIG_1 = 8'h08;
    localparam logic [7:0] TX_TRIG_2 = 8'h18;
    localparam logic [7:0] TX_TRIG_3 = 8'h1E;

    localparam logic [5:0] CODE_LINE    = 6'h06;
    localparam logic [5:0] CODE_RX_DATA = 6'h04;
    localparam logic [5:0] CODE_RX_TOUT = 6'h0C;
    localparam logic [5:0] CODE_TX      = 6'h02;
    localparam logic [5:0] CODE_MODEM   = 6'h00;
    localparam logic [5:0] CODE_XOFF    = 6'h10;
    localparam logic [5:0] CODE_FLOWPIN = 6'h20;

    typedef enum logic [2:0] {
        SRC_NONE, SRC_LINE, SRC_RX, SRC_TX, SRC_MODEM, SRC_XOFF, SRC_FLOWPIN
    } int_source_type;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0]       wdata;
    } reg_req_type;

    typedef struct packed {
        logic line_err;    // Receiver error level
        logic rx_timeout;  // Receive time-out level
        logic modem_chg;   // Modem status change level
        logic xoff_match;  // Pulse: Xoff received
        logic xon_match;   // Pulse: Xon received
        logic cts_rts_chg; // Pulse: flow pin edge
    } uart_events_type;
endpackage : uart_ictl_pkg

// *** verif/host_model.sv ***
// Host processor model driving the register bus of the FIFO control block
`timescale 1ns/1ps
`default_nettype none
module host_model
    import uart_ictl_pkg::*;
(
    input  wire logic                       clk,    // System clock
    output var  uart_ictl_pkg::reg_req_type req,    // Bus request to the block
    input  wire logic [7:0]                 rdata   // Read data, cycle after read
);
    import uart_ictl_pkg::*;

    initial begin
        req = '0;
    end

    // One-cycle write strobe; released at the edge that takes it
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask : write_reg

    // Read data stands only in the cycle after the strobe, so sample it there
    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        d = rdata;
    endtask : read_reg
endmodule : host_model
`default_nettype wire

// *** verif/tb_uart_fifo_ctrl_int_status.sv ***
// Self-checking testbench for the FIFO control and interrupt status block
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_ctrl_int_status;
    import uart_ictl_pkg::*;

    logic            clk;
    logic            sys_rst;
    reg_req_type     req;
    logic [7:0]      rdata;
    uart_events_type ev;
    logic            rx_push, rx_pop, tx_push, tx_pop;
    logic            fifo_enable, rx_flush, tx_flush, int_pending;
    logic [7:0]      rx_count, tx_count, rx_trigger;
    int              mismatches = 0;
    int              compares = 0;

    host_model host (.clk(clk), .req(req), .rdata(rdata));

    uart_fifo_ctrl_int_status #(.DEPTH(32), .CNT_W(8)) dut (
        .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .events(ev),
        .rx_push(rx_push), .rx_pop(rx_pop), .tx_push(tx_push), .tx_pop(tx_pop),
        .fifo_enable(fifo_enable), .rx_flush(rx_flush), .tx_flush(tx_flush),
        .rx_count(rx_count), .tx_count(tx_count), .rx_trigger(rx_trigger),
        .int_pending(int_pending));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask : check

    task automatic status_is(input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(ADDR_INT_STATUS, d);
        check("interrupt_status", e, d);
        check("int_pending", {7'h00, ~e[0]}, {7'h00, int_pending});
    endtask : status_is

    // Back-to-back strobes on one of the four byte-stream inputs
    task automatic strobe(input int which, input int n);
        @(posedge clk);
        case (which)
            0: rx_push <= 1'b1;
            1: rx_pop  <= 1'b1;
            2: tx_push <= 1'b1;
            default: tx_pop <= 1'b1;
        endcase
        repeat (n) @(posedge clk);
        {rx_push, rx_pop, tx_push, tx_pop} <= 4'h0;
    endtask : strobe

    task automatic ev_set(input logic [5:0] m, input logic on);
        @(posedge clk);
        ev <= on ? (ev | m) : (ev & ~m);
        @(posedge clk);
    endtask : ev_set

    task automatic ev_pulse(input logic [5:0] m);
        @(posedge clk);
        ev <= ev | m;
        @(posedge clk);
        ev <= ev & ~m;
        @(posedge clk);
    endtask : ev_pulse

    task automatic sc_reset_values;
        logic [7:0] d;
        check("fifo_enable", 8'h00, {7'h00, fifo_enable});
        status_is(8'h01);
        host.read_reg(4'hF, d);
        check("unmapped read", 8'h00, d);
    endtask : sc_reset_values

    task automatic sc_flush;
        host.write_reg(ADDR_FIFO_CTRL, 8'h01);
        #1;
        check("fifo_enable", 8'h01, {7'h00, fifo_enable});
        strobe(0, 3);
        strobe(2, 3);
        check("rx_count", 8'h03, rx_count);
        host.write_reg(ADDR_FIFO_CTRL, 8'h07);
        #1;
        check("flush pulses", 8'h03, {6'h00, rx_flush, tx_flush});
        @(posedge clk);
        #1;
        check("flush pulses", 8'h00, {6'h00, rx_flush, tx_flush});
        check("rx_count", 8'h00, rx_count);
        check("tx_count", 8'h00, tx_count);
    endtask : sc_flush

    task automatic sc_rx_levels;
        logic [7:0] exp_trig [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
        for (int i = 0; i < 4; i++) begin
            host.write_reg(ADDR_FIFO_CTRL, {i[1:0], 6'h01});
            repeat (2) @(posedge clk);
            #1;
            check("rx_trigger", exp_trig[i], rx_trigger);
        end
        host.write_reg(ADDR_RX_LEVEL, 8'h05);
        repeat (2) @(posedge clk);
        #1;
        check("rx_trigger override", 8'h05, rx_trigger);
        host.write_reg(ADDR_RX_LEVEL, 8'h00);
        host.write_reg(ADDR_FLOW_HIGH, 8'h09);
        repeat (2) @(posedge clk);
        #1;
        check("rx_trigger flow override", 8'h00, rx_trigger);
        host.write_reg(ADDR_FLOW_HIGH, 8'h00);
    endtask : sc_rx_levels

    task automatic sc_rx_ready;
        host.write_reg(ADDR_INT_ENABLE, 8'h01);
        host.write_reg(ADDR_FIFO_CTRL, 8'h47);
        strobe(0, 15);
        status_is(8'hC1);
        strobe(0, 1);
        status_is(8'hC4);
        strobe(1, 1);
        status_is(8'hC1);
    endtask : sc_rx_ready

    task automatic sc_tx_levels;
        int trig [4] = '{16, 8, 24, 30};
        host.write_reg(ADDR_INT_ENABLE, 8'h02);
        for (int i = 0; i < 4; i++) begin
            host.write_reg(ADDR_FIFO_CTRL, {2'b00, i[1:0], 4'h7});
            strobe(2, trig[i]);
            status_is(8'hC1);
            strobe(3, 1);
            if (i % 2 == 1) begin
                strobe(2, 1);
            end else begin
                status_is(8'hC2);
            end
            status_is(8'hC1);
        end
    endtask : sc_tx_levels

    task automatic sc_priority;
        host.write_reg(ADDR_FIFO_CTRL, 8'h07);
        host.write_reg(ADDR_INT_ENABLE, 8'hFF);
        host.write_reg(ADDR_ENH_FEATURE, 8'h10);
        ev_pulse(6'b000101);
        ev_set(6'b101000, 1'b1);
        strobe(2, 16);
        strobe(3, 1);
        strobe(0, 8);
        status_is(8'hC6);
        ev_set(6'b100000, 1'b0);
        status_is(8'hC4);
        strobe(1, 1);
        status_is(8'hC2);
        status_is(8'hC0);
        ev_set(6'b001000, 1'b0);
        status_is(8'hD0);
        status_is(8'hD0);
        ev_pulse(6'b000010);
        status_is(8'hE0);
        status_is(8'hC1);
        ev_set(6'b010000, 1'b1);
        status_is(8'hCC);
        ev_set(6'b010000, 1'b0);
        host.write_reg(ADDR_INT_ENABLE, 8'h00);
        ev_set(6'b100000, 1'b1);
        status_is(8'hC1);
        ev_set(6'b100000, 1'b0);
        host.write_reg(ADDR_INT_ENABLE, 8'hFF);
        host.write_reg(ADDR_ENH_FEATURE, 8'h00);
        ev_pulse(6'b000101);
        status_is(8'hC1);
        host.write_reg(ADDR_FIFO_CTRL, 8'h00);
        status_is(8'h04);
    endtask : sc_priority

    initial begin
        repeat (20000) @(posedge clk);
        $display("CHECK FAILED watchdog expected done seen hang");
        mismatches++;
        end_sim();
    end

    initial begin
        sys_rst = 1'b1;
        ev      = '0;
        {rx_push, rx_pop, tx_push, tx_pop} = 4'h0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        sc_reset_values();
        sc_flush();
        sc_rx_levels();
        sc_rx_ready();
        sc_tx_levels();
        sc_priority();
        end_sim();
    end
endmodule : tb_uart_fifo_ctrl_int_status
`default_nettype wire
